/* File: sotad_defs.vh */
// Constants for the synchronous octet transport adapter
`ifndef SOTAD_DEFS_VH
`define SOTAD_DEFS_VH

// ==========================================================
// Register byte offsets
`define SOTAD_OFS_CTRL 8'h00
`define SOTAD_OFS_DS_RATE 8'h04
`define SOTAD_OFS_DS_RESERVE 8'h08
`define SOTAD_OFS_US_RATE 8'h0C
`define SOTAD_OFS_US_RESERVE 8'h10
`define SOTAD_OFS_QOS 8'h14
`define SOTAD_OFS_STATUS 8'h18
`define SOTAD_OFS_TX_COUNT 8'h1C
`define SOTAD_OFS_RX_COUNT 8'h20

// ==========================================================
// Field positions
`define SOTAD_CTRL_TX_EN 0
`define SOTAD_CTRL_RX_EN 1
`define SOTAD_RATE_MIN_LSB 0
`define SOTAD_RATE_MAX_LSB 16
`define SOTAD_QOS_DELAY_LSB 0
`define SOTAD_QOS_ERROR_LSB 8
`define SOTAD_QOS_INP_LSB 12

// ==========================================================
// Reset values and codes
`define SOTAD_CTRL_RESET 32'h00000000
`define SOTAD_RATE_RESET 12'h000
`define SOTAD_DELAY_RESET 8'h00
`define SOTAD_ERROR_RESET 2'h0
`define SOTAD_INP_RESET 2'h0
`define SOTAD_ERROR_E3 2'h0
`define SOTAD_ERROR_E5 2'h1
`define SOTAD_ERROR_E7 2'h2
`define SOTAD_DELAY_NONE 8'h00
`define SOTAD_DELAY_LOWEST 8'h01
`define SOTAD_LAT_NONE 2'h0
`define SOTAD_LAT_LOWEST 2'h1
`define SOTAD_LAT_BOUNDED 2'h2

// ==========================================================
// Rates in units of 4000 bit/s
`define SOTAD_DS_MANDATORY 12'h7D0
`define SOTAD_US_MANDATORY 12'h0C8
`define SOTAD_RATE_CEILING 12'hFFF

`endif

/* File: sotad_fifo2.v */
// Two-entry octet buffer with registered outputs
`timescale 1ns/1ns
`default_nettype none

module sotad_fifo2 #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Fill side
    input wire in_valid,
    input wire [WIDTH-1:0] in_data,
    output reg in_ready,
    // Drain side
    output reg out_valid,
    output reg [WIDTH-1:0] out_data,
    input wire out_ready
);

    reg [WIDTH-1:0] spare;
    reg spare_valid;

    wire take = in_valid && in_ready;
    wire give = out_valid && out_ready;

    // ==========================================================
    // Head register is the output; spare holds a stalled word
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid <= 1'b0;
            out_data <= {WIDTH{1'b0}};
            spare <= {WIDTH{1'b0}};
            spare_valid <= 1'b0;
            in_ready <= 1'b1;
        end else begin
            if (!out_valid || give) begin
                if (spare_valid) begin
                    out_data <= spare;
                    out_valid <= 1'b1;
                    spare_valid <= take;
                    if (take) begin
                        spare <= in_data;
                    end
                end else begin
                    out_valid <= take;
                    if (take) begin
                        out_data <= in_data;
                    end
                end
            end else if (take) begin
                spare <= in_data;
                spare_valid <= 1'b1;
            end
            // Ready falls once both entries hold words
            in_ready <= !(out_valid && !give &&
                          (spare_valid || take));
        end
    end

endmodule
`default_nettype wire

/* File: sotad_partner.sv */
// Framing sublayer model: bearer requests, confirm sink, indicate source
`timescale 1ns/1ns
`default_nettype none

module sotad_partner (
    // Control
    input wire logic pclk, go, stall,
    // Framing sublayer side
    input wire logic fs_bearer_confirm, fs_indicate_ready,
    output logic fs_bearer_request, fs_confirm_ready, fs_bearer_indicate,
    output logic [7:0] fs_indicate_data
);
    integer seed = 48203;
    initial begin
        fs_bearer_request = 0;
        fs_confirm_ready = 0;
        fs_bearer_indicate = 0;
        fs_indicate_data = 8'h00;
    end
    // Idle data changes every cycle so a stale octet cannot pass
    always @(posedge pclk) begin
        fs_bearer_request <= go && (($random(seed) & 3) == 0);
        fs_confirm_ready <= !stall && ($random(seed) & 1);
        if (!fs_bearer_indicate || fs_indicate_ready) begin
            fs_bearer_indicate <= go && ($random(seed) & 1);
            fs_indicate_data <= $random(seed);
        end
    end
endmodule
`default_nettype wire

/* File: sotad_props.sv */
// Port checker for the synchronous octet transport adapter
`timescale 1ns/1ns
`default_nettype none
`include "sotad_defs.vh"

module sotad_props (
    // Watched ports
    input wire logic pclk, presetn, fs_bearer_request, stream_pull_request,
    input wire logic stream_supply_confirm, stream_supply_ready,
    input wire logic fs_bearer_confirm, fs_confirm_ready,
    input wire logic fs_bearer_indicate, fs_indicate_ready,
    input wire logic stream_deliver_indicate, stream_deliver_ready,
    input wire logic [7:0] stream_supply_data, fs_confirm_data,
    input wire logic [7:0] fs_indicate_data, stream_deliver_data,
    input wire logic [7:0] latency_bound,
    input wire logic [1:0] latency_mode, error_ceiling,
    input wire logic config_valid, convergence_indicator_bit_zero,
    input wire logic convergence_indicator_bit_one
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire tx_take = stream_supply_confirm && stream_supply_ready;
    wire rx_take = fs_bearer_indicate && fs_indicate_ready;
    // ==========================================================
    // Properties
    a_ind_bits: assert property (
        convergence_indicator_bit_zero && convergence_indicator_bit_one)
        else $error("indicator bit low");
    a_pull_cause: assert property (
        $rose(stream_pull_request) |-> $past(fs_bearer_request))
        else $error("pull request without bearer request");
    a_pull_clear: assert property (
        stream_pull_request && tx_take && !fs_bearer_request
        |=> !stream_pull_request) else $error("pull request stuck");
    a_tx_pass: assert property (
        tx_take && !fs_bearer_confirm |=> fs_bearer_confirm
        && fs_confirm_data == $past(stream_supply_data))
        else $error("supplied octet not confirmed");
    a_tx_hold: assert property (
        fs_bearer_confirm && !fs_confirm_ready
        |=> fs_bearer_confirm && $stable(fs_confirm_data))
        else $error("confirm octet lost");
    a_rx_pass: assert property (
        rx_take && !stream_deliver_indicate |=> stream_deliver_indicate
        && stream_deliver_data == $past(fs_indicate_data))
        else $error("indicated octet not delivered");
    a_rx_hold: assert property (
        stream_deliver_indicate && !stream_deliver_ready
        |=> stream_deliver_indicate && $stable(stream_deliver_data))
        else $error("delivered octet lost");
    a_lat_none: assert property (
        latency_bound == `SOTAD_DELAY_NONE
        |-> latency_mode == `SOTAD_LAT_NONE) else $error("zero bound");
    a_lat_low: assert property (
        latency_bound == `SOTAD_DELAY_LOWEST
        |-> latency_mode == `SOTAD_LAT_LOWEST) else $error("unit bound");
    a_lat_bound: assert property (
        latency_bound > 8'h01 |-> latency_mode == `SOTAD_LAT_BOUNDED)
        else $error("bounded mode");
    a_err_code: assert property (
        error_ceiling == 2'h3 |-> !config_valid)
        else $error("bad error code accepted");
endmodule

bind sotad_top sotad_props chk_u (.*);
`default_nettype wire

/* File: sotad_top.v */
// Synchronous octet transport adapter with APB configuration
// Function
// R1 - Latency bound accepted from zero upward; zero means no bound imposed
// R2 - Latency bound of one requests lowest achievable delay
// R3 - All latency bounds, error ceilings 1e-3/5/7, protection 0,1/2,1,2 held
// R4 - Downstream min, max, reserved rates supported up to 8 Mbit/s
// R5 - Upstream min, max, reserved rates supported up to 800 kbit/s
// R6 - Rates above the mandatory ones are optionally allowed
// R7 - Bearer request from framing sublayer raises a stream pull request
// R8 - Supplied octets are handed to the framing sublayer as bearer confirm
// R9 - Bearer indicate octets are delivered to the sink as stream indicate
// R10 - Both convergence indicator bits are driven constantly to one
// R11 - Source answers each pull request with one or more octets
// R12 - Octets pass unmodified, in order, never added or dropped
`timescale 1ns/1ns
`default_nettype none
`include "sotad_defs.vh"

module sotad_top #(
    parameter RATE_LIMIT = `SOTAD_RATE_CEILING,
    parameter COUNT_WIDTH = 32
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Framing sublayer, transmit
    input wire fs_bearer_request,
    output reg fs_bearer_confirm,
    output reg [7:0] fs_confirm_data,
    input wire fs_confirm_ready,
    // Framing sublayer, receive
    input wire fs_bearer_indicate,
    input wire [7:0] fs_indicate_data,
    output reg fs_indicate_ready,
    // Higher-layer source
    output reg stream_pull_request,
    input wire stream_supply_confirm,
    input wire [7:0] stream_supply_data,
    output reg stream_supply_ready,
    // Higher-layer sink
    output reg stream_deliver_indicate,
    output reg [7:0] stream_deliver_data,
    input wire stream_deliver_ready,
    // Configuration in force
    output reg [1:0] latency_mode,
    output reg [7:0] latency_bound,
    output reg [1:0] error_ceiling,
    output reg [1:0] impulse_protection_floor,
    output reg config_valid,
    // Overhead indicator bits
    output reg convergence_indicator_bit_zero,
    output reg convergence_indicator_bit_one
);

    // ==========================================================
    // Configuration registers
    reg tx_enable;
    reg rx_enable;
    reg [11:0] ds_min;
    reg [11:0] ds_max;
    reg [11:0] ds_reserve;
    reg [11:0] us_min;
    reg [11:0] us_max;
    reg [11:0] us_reserve;
    reg [7:0] delay_max;
    reg [1:0] error_code;
    reg [1:0] inp_code;
    reg [COUNT_WIDTH-1:0] tx_count;
    reg [COUNT_WIDTH-1:0] rx_count;

    localparam [11:0] LIMIT = RATE_LIMIT;

    wire setup = psel && !penable;
    // Writes land only at the edge that ends the access phase
    wire wr_access = psel && penable && pready && pwrite;
    wire [31:0] ds_rate_word = {4'h0, ds_max, 4'h0, ds_min};
    wire [31:0] us_rate_word = {4'h0, us_max, 4'h0, us_min};
    wire [31:0] qos_word = {18'h00000, inp_code, 2'h0, error_code,
                            delay_max};

    // ==========================================================
    // Rate and code checks
    // Rates above the mandatory ceiling pass up to LIMIT [R6]
    wire ds_order_ok = (ds_min <= ds_reserve) &&
                       (ds_reserve <= ds_max);
    wire us_order_ok = (us_min <= us_reserve) &&
                       (us_reserve <= us_max);
    // Every rate field meets the ceiling, so a bad reserve cannot hide
    wire ds_range_ok = (ds_min <= LIMIT) &&
                       (ds_reserve <= LIMIT) &&
                       (ds_max <= LIMIT) &&
                       (LIMIT >= `SOTAD_DS_MANDATORY); // [R4]
    wire us_range_ok = (us_min <= LIMIT) &&
                       (us_reserve <= LIMIT) &&
                       (us_max <= LIMIT) &&
                       (LIMIT >= `SOTAD_US_MANDATORY); // [R5]
    // Codes 0, 1, 2 stand for ceilings of one in 1e3, 1e5 and 1e7
    // Code 3 is the only unsupported error ceiling [R3]
    wire error_ok = (error_code != 2'h3);
    wire next_valid = ds_order_ok && us_order_ok &&
                      ds_range_ok && us_range_ok && error_ok;

    // Bounds 0 and 1 select a mode; only larger values are delays
    reg [1:0] next_lat_mode;
    always @* begin
        next_lat_mode = `SOTAD_LAT_BOUNDED;
        case (delay_max)
            `SOTAD_DELAY_NONE: next_lat_mode = `SOTAD_LAT_NONE; // [R1]
            `SOTAD_DELAY_LOWEST: next_lat_mode = `SOTAD_LAT_LOWEST; // [R2]
            default: next_lat_mode = `SOTAD_LAT_BOUNDED; // [R1]
        endcase
    end

    // ==========================================================
    // Register writes
    // Map: 00 control, 04 and 0C rate pairs, 08 and 10 reserves,
    // 14 quality codes, 18 status, 1C and 20 octet counts
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_enable <= 1'b0;
            rx_enable <= 1'b0;
            ds_min <= `SOTAD_RATE_RESET;
            ds_max <= `SOTAD_RATE_RESET;
            ds_reserve <= `SOTAD_RATE_RESET;
            us_min <= `SOTAD_RATE_RESET;
            us_max <= `SOTAD_RATE_RESET;
            us_reserve <= `SOTAD_RATE_RESET;
            delay_max <= `SOTAD_DELAY_RESET;
            error_code <= `SOTAD_ERROR_RESET;
            inp_code <= `SOTAD_INP_RESET;
        end else if (wr_access) begin
            case (paddr)
                `SOTAD_OFS_CTRL: begin
                    tx_enable <= pwdata[`SOTAD_CTRL_TX_EN];
                    rx_enable <= pwdata[`SOTAD_CTRL_RX_EN];
                end
                `SOTAD_OFS_DS_RATE: begin
                    ds_min <= pwdata[`SOTAD_RATE_MIN_LSB +: 12]; // [R4]
                    ds_max <= pwdata[`SOTAD_RATE_MAX_LSB +: 12]; // [R4]
                end
                `SOTAD_OFS_DS_RESERVE: begin
                    ds_reserve <= pwdata[11:0]; // [R4]
                end
                `SOTAD_OFS_US_RATE: begin
                    us_min <= pwdata[`SOTAD_RATE_MIN_LSB +: 12]; // [R5]
                    us_max <= pwdata[`SOTAD_RATE_MAX_LSB +: 12]; // [R5]
                end
                `SOTAD_OFS_US_RESERVE: begin
                    us_reserve <= pwdata[11:0]; // [R5]
                end
                `SOTAD_OFS_QOS: begin
                    delay_max <= pwdata[`SOTAD_QOS_DELAY_LSB +: 8]; // [R1]
                    error_code <= pwdata[`SOTAD_QOS_ERROR_LSB +: 2]; // [R3]
                    inp_code <= pwdata[`SOTAD_QOS_INP_LSB +: 2]; // [R3]
                end
                default: begin
                    tx_enable <= tx_enable;
                end
            endcase
        end
    end

    // ==========================================================
    // Read mux and bus answer
    reg [31:0] next_rdata;
    reg next_err;
    always @* begin
        next_rdata = 32'h00000000;
        next_err = 1'b0;
        case (paddr)
            `SOTAD_OFS_CTRL: next_rdata = {30'h00000000, rx_enable,
                                           tx_enable};
            `SOTAD_OFS_DS_RATE: next_rdata = ds_rate_word;
            `SOTAD_OFS_DS_RESERVE: next_rdata = {20'h00000, ds_reserve};
            `SOTAD_OFS_US_RATE: next_rdata = us_rate_word;
            `SOTAD_OFS_US_RESERVE: next_rdata = {20'h00000, us_reserve};
            `SOTAD_OFS_QOS: next_rdata = qos_word;
            `SOTAD_OFS_STATUS: next_rdata = {24'h000000,
                convergence_indicator_bit_one,
                convergence_indicator_bit_zero,
                stream_pull_request, config_valid,
                2'h0, latency_mode};
            `SOTAD_OFS_TX_COUNT: next_rdata = tx_count;
            `SOTAD_OFS_RX_COUNT: next_rdata = rx_count;
            default: next_err = 1'b1;
        endcase
    end

    // Zero wait: the answer is ready in the access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && next_err;
            if (setup && !pwrite) begin
                prdata <= next_rdata;
            end
        end
    end

    // ==========================================================
    // Configuration in force and indicator bits
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latency_mode <= `SOTAD_LAT_NONE;
            latency_bound <= `SOTAD_DELAY_RESET;
            error_ceiling <= `SOTAD_ERROR_RESET;
            impulse_protection_floor <= `SOTAD_INP_RESET;
            config_valid <= 1'b0;
            convergence_indicator_bit_zero <= 1'b1;
            convergence_indicator_bit_one <= 1'b1;
        end else begin
            latency_mode <= next_lat_mode; // [R1] [R2]
            latency_bound <= delay_max; // [R1]
            error_ceiling <= error_code; // [R3]
            impulse_protection_floor <= inp_code; // [R3]
            config_valid <= next_valid; // [R3]
            // Fixed at one; no write path can change them
            convergence_indicator_bit_zero <= 1'b1; // [R10]
            convergence_indicator_bit_one <= 1'b1; // [R10]
        end
    end

    // ==========================================================
    // Transmit path: pull request, buffer, bearer confirm
    wire tx_in_ready;
    wire tx_out_valid;
    wire [7:0] tx_out_data;
    wire tx_take = stream_supply_confirm && stream_supply_ready;

    // Request set wins over the clear by the first octet taken
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stream_pull_request <= 1'b0;
        end else if (!tx_enable) begin
            stream_pull_request <= 1'b0;
        end else if (fs_bearer_request) begin
            stream_pull_request <= 1'b1; // [R7]
        end else if (tx_take) begin
            stream_pull_request <= 1'b0; // [R11]
        end
    end

    // Gate source by enable so a disabled path takes nothing
    always @* begin
        fs_bearer_confirm = tx_out_valid; // [R8]
        fs_confirm_data = tx_out_data; // [R12]
        stream_supply_ready = tx_in_ready && tx_enable;
    end

    sotad_fifo2 #(
        .WIDTH(8)
    ) u_tx_buf (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(stream_supply_confirm && tx_enable), // [R12]
        .in_data(stream_supply_data),
        .in_ready(tx_in_ready),
        .out_valid(tx_out_valid),
        .out_data(tx_out_data),
        .out_ready(fs_confirm_ready) // [R8]
    );

    // ==========================================================
    // Receive path: bearer indicate, buffer, stream indicate
    // Disabling rx stops intake only; held words still drain to the sink
    wire rx_in_ready;
    wire rx_out_valid;
    wire [7:0] rx_out_data;
    wire rx_take = fs_bearer_indicate && fs_indicate_ready;

    always @* begin
        stream_deliver_indicate = rx_out_valid; // [R9]
        stream_deliver_data = rx_out_data; // [R12]
        fs_indicate_ready = rx_in_ready && rx_enable;
    end

    sotad_fifo2 #(
        .WIDTH(8)
    ) u_rx_buf (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(fs_bearer_indicate && rx_enable), // [R9]
        .in_data(fs_indicate_data),
        .in_ready(rx_in_ready),
        .out_valid(rx_out_valid),
        .out_data(rx_out_data),
        .out_ready(stream_deliver_ready) // [R12]
    );

    // ==========================================================
    // Octet counters, wrap silently
    // Counted where octets enter the buffers, so held words count too
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_count <= {COUNT_WIDTH{1'b0}};
            rx_count <= {COUNT_WIDTH{1'b0}};
        end else begin
            if (tx_take) begin
                tx_count <= tx_count + 1'b1;
            end
            if (rx_take) begin
                rx_count <= rx_count + 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the synchronous octet transport adapter
`timescale 1ns/1ns
`default_nettype none
`include "sotad_defs.vh"

module tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00, stream_supply_data = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic stream_supply_confirm = 0, stream_deliver_ready = 0;
    logic go = 0, stall = 0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, fs_bearer_request, fs_bearer_confirm;
    wire logic fs_confirm_ready, fs_bearer_indicate, fs_indicate_ready;
    wire logic stream_pull_request, stream_supply_ready, config_valid;
    wire logic stream_deliver_indicate, ind0, ind1;
    wire logic [7:0] fs_confirm_data, fs_indicate_data, stream_deliver_data;
    wire logic [7:0] latency_bound;
    wire logic [1:0] latency_mode, error_ceiling, inp_floor;
    integer seed = 48203, mismatches = 0, n_checks = 0, cycles = 0;
    logic [31:0] ntx = 0, nrx = 0;
    logic [32:0] rdq[$];
    logic [7:0] txq[$], rxq[$];

    sotad_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fs_bearer_request(fs_bearer_request),
        .fs_bearer_confirm(fs_bearer_confirm),
        .fs_confirm_data(fs_confirm_data), .fs_confirm_ready(fs_confirm_ready),
        .fs_bearer_indicate(fs_bearer_indicate),
        .fs_indicate_data(fs_indicate_data),
        .fs_indicate_ready(fs_indicate_ready),
        .stream_pull_request(stream_pull_request),
        .stream_supply_confirm(stream_supply_confirm),
        .stream_supply_data(stream_supply_data),
        .stream_supply_ready(stream_supply_ready),
        .stream_deliver_indicate(stream_deliver_indicate),
        .stream_deliver_data(stream_deliver_data),
        .stream_deliver_ready(stream_deliver_ready),
        .latency_mode(latency_mode), .latency_bound(latency_bound),
        .error_ceiling(error_ceiling), .impulse_protection_floor(inp_floor),
        .config_valid(config_valid), .convergence_indicator_bit_zero(ind0),
        .convergence_indicator_bit_one(ind1));
    sotad_partner p_u (.pclk(pclk), .go(go), .stall(stall),
        .fs_bearer_confirm(fs_bearer_confirm),
        .fs_indicate_ready(fs_indicate_ready),
        .fs_bearer_request(fs_bearer_request),
        .fs_confirm_ready(fs_confirm_ready),
        .fs_bearer_indicate(fs_bearer_indicate),
        .fs_indicate_data(fs_indicate_data));

    initial begin
        forever #2 pclk = ~pclk;
    end
    // ==========================================================
    // Checking and closing
    task chk(input bit ok);
        n_checks++;
        if (!ok) begin
            mismatches++;
            $display("[ERR] %0t mismatch", $time);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles > 12000) begin
            mismatches++;
            stop_test();
        end
    end
    // ==========================================================
    // Higher layer source and sink, result watcher
    always @(posedge pclk) begin
        stream_deliver_ready <= !stall && ($random(seed) & 1);
        if (!stream_supply_confirm || stream_supply_ready) begin
            // One or more octets offered per pull request
            stream_supply_confirm <= go && stream_pull_request;
            stream_supply_data <= $random(seed);
        end
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk(rdq.size() > 0 && {pslverr, prdata} === rdq.pop_front());
        if (fs_bearer_confirm && fs_confirm_ready)
            chk(txq.size() > 0 && fs_confirm_data === txq.pop_front());
        if (stream_deliver_indicate && stream_deliver_ready)
            chk(rxq.size() > 0 && stream_deliver_data === rxq.pop_front());
        if (stream_supply_confirm && stream_supply_ready) begin
            txq.push_back(stream_supply_data);
            ntx++;
        end
        if (fs_bearer_indicate && fs_indicate_ready) begin
            rxq.push_back(fs_indicate_data);
            nrx++;
        end
    end
    // ==========================================================
    // APB master
    task apb(input bit w, input [7:0] a, input [31:0] d, input [32:0] e);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w)
            rdq.push_back(e);
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
    endtask
    task cfg(input [11:0] a, b, c, f, g, h, input [1:0] er, input v);
        apb(1, `SOTAD_OFS_DS_RATE, {4'h0, b, 4'h0, a}, 0);
        apb(1, `SOTAD_OFS_DS_RESERVE, {20'h0, c}, 0);
        apb(1, `SOTAD_OFS_US_RATE, {4'h0, g, 4'h0, f}, 0);
        apb(1, `SOTAD_OFS_US_RESERVE, {20'h0, h}, 0);
        apb(1, `SOTAD_OFS_QOS, {22'h0, er, 8'h00}, 0);
        repeat (2) @(posedge pclk);
        chk(config_valid === v);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        bit [7:0] dl[4] = '{8'h00, 8'h01, 8'h02, 8'hFF};
        repeat (6) @(posedge pclk);
        presetn <= 1;
        apb(0, `SOTAD_OFS_CTRL, 0, 33'h000000000);
        apb(0, `SOTAD_OFS_QOS, 0, 33'h000000000);
        apb(0, 8'h24, 0, 33'h100000000);
        foreach (dl[k])
            for (int e = 0; e < 3; e++)
                for (int i = 0; i < 4; i++) begin
                    apb(1, `SOTAD_OFS_QOS, (i << 12) | (e << 8) | dl[k], 0);
                    apb(0, `SOTAD_OFS_QOS, 0, (i << 12) | (e << 8) | dl[k]);
                    @(posedge pclk);
                    chk(latency_bound === dl[k] && error_ceiling === e);
                    chk(inp_floor === i);
                    chk(latency_mode === (dl[k] == 0 ? `SOTAD_LAT_NONE :
                        dl[k] == 1 ? `SOTAD_LAT_LOWEST : `SOTAD_LAT_BOUNDED));
                end
        cfg(12'h7D0, 12'h7D0, 12'h7D0, 12'h0C8, 12'h0C8, 12'h0C8, 0, 1);
        cfg(12'h000, 12'hFFF, 12'h800, 12'h010, 12'hFFF, 12'h100, 2, 1);
        cfg(12'h100, 12'h7D0, 12'h7D1, 12'h0C8, 12'h0C8, 12'h0C8, 0, 0);
        cfg(12'h0C8, 12'h7D0, 12'h0C8, 12'h0C9, 12'h0C8, 12'h0C8, 1, 0);
        cfg(12'h7D0, 12'h7D0, 12'h7D0, 12'h0C8, 12'h0C8, 12'h0C8, 3, 0);
        apb(0, `SOTAD_OFS_STATUS, 0, 33'h0000000C0);
        apb(1, `SOTAD_OFS_CTRL, 32'h00000003, 0);
        go <= 1;
        repeat (1500) @(posedge pclk);
        // Both far sides stall so each buffer must fill and refuse
        stall <= 1;
        repeat (40) @(posedge pclk);
        chk(fs_indicate_ready === 0 && stream_supply_ready === 0);
        chk(stream_deliver_indicate === 1 && fs_bearer_confirm === 1);
        stall <= 0;
        repeat (500) @(posedge pclk);
        go <= 0;
        repeat (300) @(posedge pclk);
        chk(txq.size() == 0 && rxq.size() == 0 && ntx > 0 && nrx > 0);
        apb(0, `SOTAD_OFS_TX_COUNT, 0, {1'b0, ntx});
        apb(0, `SOTAD_OFS_RX_COUNT, 0, {1'b0, nrx});
        apb(1, `SOTAD_OFS_CTRL, 32'h00000000, 0);
        repeat (2) @(posedge pclk);
        chk(stream_pull_request === 0);
        stop_test();
    end
endmodule
`default_nettype wire
